// *** design/crf_params.svh ***
// Offsets, flag bit positions and widths of the CPU register set
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH

// Register byte offsets on the APB port
`define CRF_OFS_DATA0 8'h00
`define CRF_OFS_DATA1 8'h04
`define CRF_OFS_DATA2 8'h08
`define CRF_OFS_DATA3 8'h0C
`define CRF_OFS_D0_LO 8'h10
`define CRF_OFS_D0_HI 8'h14
`define CRF_OFS_D1_LO 8'h18
`define CRF_OFS_D1_HI 8'h1C
`define CRF_OFS_PAIR_LO 8'h20
`define CRF_OFS_PAIR_HI 8'h24
`define CRF_OFS_ADDR0 8'h28
`define CRF_OFS_ADDR1 8'h2C
`define CRF_OFS_ADDR_PAIR 8'h30
`define CRF_OFS_FB 8'h34
`define CRF_OFS_VECTOR_TABLE_BASE 8'h38
`define CRF_OFS_PC 8'h3C
`define CRF_OFS_USP 8'h40
`define CRF_OFS_ISP 8'h44
`define CRF_OFS_SB 8'h48
`define CRF_OFS_FLG 8'h4C
`define CRF_OFS_ASP 8'h50

// Flag register field positions
`define CRF_FLG_C 0
`define CRF_FLG_D 1
`define CRF_FLG_Z 2
`define CRF_FLG_S 3
`define CRF_FLG_B 4
`define CRF_FLG_O 5
`define CRF_FLG_I 6
`define CRF_FLG_U 7

// Widths and reset values
`define CRF_W_WORD 16
`define CRF_W_LONG 20
`define CRF_W_FLG 11
`define CRF_RST_WORD 16'h0000
`define CRF_RST_LONG 20'h00000
`define CRF_RST_FLG 11'h000

`endif

// *** design/crf_pkg.sv ***
// Types shared by the CPU register set and its neighbours
`default_nettype none
package crf_pkg;

    // Operand width of an ALU result
    typedef enum logic [1:0] {
        CRF_SZ8,
        CRF_SZ16,
        CRF_SZ32
    } crf_size_type;

    // APB request from the bus master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } crf_apb_req_type;

    // APB answer
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } crf_apb_rsp_type;

    // Update from sequencer and ALU
    typedef struct packed {
        logic dst_en;
        logic [7:0] dst_ofs;
        logic [31:0] dst_data;
        logic flag_en;
        crf_size_type size;
        logic carry;
        logic ovf;
        logic [31:0] result;
        logic pc_en;
        logic [2:0] pc_step;
    } crf_core_type;

    // Registered operand view for the core
    typedef struct packed {
        logic [31:0] pair_lo;
        logic [31:0] pair_hi;
        logic [31:0] addr_pair;
        logic [15:0] fb;
        logic [15:0] sb;
        logic [19:0] vector_table_base;
        logic [19:0] pc;
        logic [15:0] asp;
        logic [10:0] cpu_state_flags;
    } crf_view_type;

endpackage
`default_nettype wire

// *** design/crf_regfile.sv ***
// Banked CPU register set with flag register and APB access
// Contract
// RULE_01: four 16-bit general data registers
// RULE_02: first two data registers split into bytes
// RULE_03: data pairs 2:0 and 3:1 form 32 bits
// RULE_04: two 16-bit address registers, also operands
// RULE_05: address registers pair, one as upper word
// RULE_06: 16-bit frame base register
// RULE_07: 20-bit vector table base register
// RULE_08: 20-bit next instruction address
// RULE_09: separate user and handler stack pointers
// RULE_10: stack-select flag picks active stack pointer
// RULE_11: 16-bit static base register
// RULE_12: 11-bit flag register of CPU state
// RULE_13: carry flag takes carry, borrow, shift-out
// RULE_14: software keeps debug flag at zero
// RULE_15: zero flag set on zero result
// RULE_16: sign flag set on negative result
// RULE_17: bank flag selects register bank
// RULE_18: overflow flag set on signed overflow
// RULE_19: data, address, frame base duplicated per bank
//
// Local design decisions: the register offsets and register access over APB.
`include "crf_params.svh"
`default_nettype none

module crf_regfile (
    input wire logic mclk,
    input wire logic rst,
    input wire crf_pkg::crf_apb_req_type apb_req,
    output var crf_pkg::crf_apb_rsp_type apb_rsp,
    input wire crf_pkg::crf_core_type core,
    output var crf_pkg::crf_view_type view
);
    import crf_pkg::*;

    // Banked storage: one copy per bank
    // Data words, indexed by bank, then register number
    logic [1:0][3:0][15:0] data_q; // RULE_19
    logic [1:0][3:0][15:0] data_d;
    // Address pointers; a bank switch moves no data
    logic [1:0][1:0][15:0] addr_q;
    logic [1:0][1:0][15:0] addr_d;
    // Frame base, also one per bank
    logic [1:0][15:0] fb_q;
    logic [1:0][15:0] fb_d;

    // Shared registers
    // Vector table base, a full 20-bit address
    logic [19:0] vector_table_base_q; // RULE_07
    logic [19:0] vector_table_base_d;
    // Next instruction address, wraps at 20 bits
    logic [19:0] pc_q; // RULE_08
    logic [19:0] pc_d;
    // User stack pointer
    logic [15:0] usp_q; // RULE_09
    logic [15:0] usp_d;
    // Handler stack pointer, in use while U is clear
    logic [15:0] isp_q;
    logic [15:0] isp_d;
    // Static base, shared by both banks
    logic [15:0] sb_q; // RULE_11
    logic [15:0] sb_d;
    // Flag word; bits 8 to 10 are plain storage
    logic [10:0] flg_q; // RULE_12
    logic [10:0] flg_d;

    // Bank in force now and after this cycle
    wire logic bank = flg_q[`CRF_FLG_B]; // RULE_17
    // Next bank feeds the operand view
    wire logic bank_n = flg_d[`CRF_FLG_B];

    // Active stack pointer, handler one while U is clear
    wire logic [15:0] asp =
        flg_q[`CRF_FLG_U] ? usp_q : isp_q; // RULE_10
    wire logic [15:0] asp_n =
        flg_d[`CRF_FLG_U] ? usp_d : isp_d;

    // APB phase decode
    wire logic setup = apb_req.psel & ~apb_req.penable;
    wire logic access = apb_req.psel & apb_req.penable;
    // Byte address; all eight bits are decoded
    wire logic [7:0] paddr = apb_req.paddr;

    // Map check: aligned words up to the active pointer
    wire logic mapped = (paddr <= `CRF_OFS_ASP) &&
        (paddr[1:0] == 2'b00);

    // Write fires only at the edge that completes the access
    wire logic apb_wr = access & apb_rsp.pready &
        apb_req.pwrite & mapped;

    // Two writers; the core comes second so it wins
    wire logic [1:0] w_en = {core.dst_en, apb_wr};
    // Both writers share one offset code space
    wire logic [1:0][7:0] w_ofs = {core.dst_ofs, paddr};
    wire logic [1:0][31:0] w_dat = {core.dst_data,
        apb_req.pwdata};

    // Result taken unmasked; the size applies in the tests below
    wire logic [31:0] res = core.result;
    // Zero test covers only the bytes of the operand size
    wire logic res_zero =
        (core.size == CRF_SZ8) ? (res[7:0] == 8'h00) :
        (core.size == CRF_SZ16) ? (res[15:0] == 16'h0000) :
        (res == 32'h00000000);
    // Sign is the top bit of the sized result
    wire logic res_neg =
        (core.size == CRF_SZ8) ? res[7] :
        (core.size == CRF_SZ16) ? res[15] : res[31];

    // Next-state: writes, then flag and PC updates
    always_comb begin
        logic [7:0] ofs;
        logic [31:0] dat;
        ofs = 8'h00;
        dat = 32'h00000000;
        // Everything holds unless a writer hits it
        data_d = data_q;
        addr_d = addr_q;
        fb_d = fb_q;
        vector_table_base_d = vector_table_base_q;
        pc_d = pc_q;
        usp_d = usp_q;
        isp_d = isp_q;
        sb_d = sb_q;
        flg_d = flg_q;
        // APB first, then the core, so the core lands last
        for (int k = 0; k < 2; k++) begin
            ofs = w_ofs[k];
            dat = w_dat[k];
            if (w_en[k]) begin
                case (ofs)
                    // Whole data words
                    `CRF_OFS_DATA0, `CRF_OFS_DATA1,
                    `CRF_OFS_DATA2, `CRF_OFS_DATA3: begin
                        data_d[bank][ofs[3:2]] = dat[15:0]; // RULE_01
                    end
                    // Low byte keeps the high byte
                    `CRF_OFS_D0_LO, `CRF_OFS_D1_LO: begin
                        data_d[bank][ofs[3]][7:0] = dat[7:0]; // RULE_02
                    end
                    // High byte keeps the low byte
                    `CRF_OFS_D0_HI, `CRF_OFS_D1_HI: begin
                        data_d[bank][ofs[3]][15:8] = dat[7:0]; // RULE_02
                    end
                    // Register two is the upper word
                    `CRF_OFS_PAIR_LO: begin
                        data_d[bank][0] = dat[15:0]; // RULE_03
                        data_d[bank][2] = dat[31:16];
                    end
                    // Register three is the upper word
                    `CRF_OFS_PAIR_HI: begin
                        data_d[bank][1] = dat[15:0]; // RULE_03
                        data_d[bank][3] = dat[31:16];
                    end
                    // Address pointer zero
                    `CRF_OFS_ADDR0: begin
                        addr_d[bank][0] = dat[15:0]; // RULE_04
                    end
                    // Address pointer one
                    `CRF_OFS_ADDR1: begin
                        addr_d[bank][1] = dat[15:0]; // RULE_04
                    end
                    // Address pair, pointer one on top
                    `CRF_OFS_ADDR_PAIR: begin
                        addr_d[bank][0] = dat[15:0]; // RULE_05
                        addr_d[bank][1] = dat[31:16];
                    end
                    // Frame base of the bank in force
                    `CRF_OFS_FB: begin
                        fb_d[bank] = dat[15:0]; // RULE_06
                    end
                    // Vector base takes the low 20 bits
                    `CRF_OFS_VECTOR_TABLE_BASE: begin
                        vector_table_base_d = dat[19:0]; // RULE_07
                    end
                    // Jump target; a same-cycle advance wins
                    `CRF_OFS_PC: begin
                        pc_d = dat[19:0]; // RULE_08
                    end
                    // User pointer, whatever U says
                    `CRF_OFS_USP: begin
                        usp_d = dat[15:0]; // RULE_09
                    end
                    // Handler pointer, whatever U says
                    `CRF_OFS_ISP: begin
                        isp_d = dat[15:0]; // RULE_09
                    end
                    // Static base
                    `CRF_OFS_SB: begin
                        sb_d = dat[15:0]; // RULE_11
                    end
                    // Whole flag word, debug bit included
                    `CRF_OFS_FLG: begin
                        flg_d = dat[10:0]; // RULE_12
                    end
                    // Push and pop land on the selected pointer
                    `CRF_OFS_ASP: begin
                        if (flg_q[`CRF_FLG_U]) begin // RULE_10
                            usp_d = dat[15:0];
                        end else begin
                            isp_d = dat[15:0];
                        end
                    end
                    // Unmapped offsets store nothing
                    default: begin
                        ofs = 8'h00;
                    end
                endcase
            end
        end
        // ALU status beats a same-cycle flag word write
        // C and O arrive ready-made from the ALU
        if (core.flag_en) begin
            flg_d[`CRF_FLG_C] = core.carry; // RULE_13
            flg_d[`CRF_FLG_Z] = res_zero; // RULE_15
            flg_d[`CRF_FLG_S] = res_neg; // RULE_16
            flg_d[`CRF_FLG_O] = core.ovf; // RULE_18
        end
        // Sequencer advance; a same-cycle load is overridden
        if (core.pc_en) begin
            pc_d = 20'(pc_q + 20'(core.pc_step)); // RULE_08
        end
    end

    // Read mux for the APB; reads follow the current bank
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h00000000;
        case (paddr)
            // Whole data word of the bank in force
            `CRF_OFS_DATA0, `CRF_OFS_DATA1,
            `CRF_OFS_DATA2, `CRF_OFS_DATA3: begin
                rdata[15:0] = data_q[bank][paddr[3:2]];
            end
            // Low byte, zero above it
            `CRF_OFS_D0_LO, `CRF_OFS_D1_LO: begin
                rdata[7:0] = data_q[bank][paddr[3]][7:0];
            end
            // High byte, returned in the low lane
            `CRF_OFS_D0_HI, `CRF_OFS_D1_HI: begin
                rdata[7:0] = data_q[bank][paddr[3]][15:8];
            end
            // Words zero and two as one operand
            `CRF_OFS_PAIR_LO: begin
                rdata = {data_q[bank][2], data_q[bank][0]};
            end
            // Words one and three as one operand
            `CRF_OFS_PAIR_HI: begin
                rdata = {data_q[bank][3], data_q[bank][1]};
            end
            // Address pointer zero
            `CRF_OFS_ADDR0: begin
                rdata[15:0] = addr_q[bank][0];
            end
            // Address pointer one
            `CRF_OFS_ADDR1: begin
                rdata[15:0] = addr_q[bank][1];
            end
            // Both pointers, pointer one on top
            `CRF_OFS_ADDR_PAIR: begin
                rdata = {addr_q[bank][1], addr_q[bank][0]};
            end
            // Frame base of the bank in force
            `CRF_OFS_FB: begin
                rdata[15:0] = fb_q[bank];
            end
            // Vector table base
            `CRF_OFS_VECTOR_TABLE_BASE: begin
                rdata[19:0] = vector_table_base_q;
            end
            // Next instruction address
            `CRF_OFS_PC: begin
                rdata[19:0] = pc_q;
            end
            // User stack pointer
            `CRF_OFS_USP: begin
                rdata[15:0] = usp_q;
            end
            // Handler stack pointer
            `CRF_OFS_ISP: begin
                rdata[15:0] = isp_q;
            end
            // Static base
            `CRF_OFS_SB: begin
                rdata[15:0] = sb_q;
            end
            // Flag word
            `CRF_OFS_FLG: begin
                rdata[10:0] = flg_q;
            end
            // Whichever pointer the U flag selects
            `CRF_OFS_ASP: begin
                rdata[15:0] = asp;
            end
            // Unmapped reads return zero
            default: begin
                rdata = 32'h00000000;
            end
        endcase
    end

    // Banked storage; no reset values are defined for it,
    // zero is used so simulation never sees unknowns
    // A banked write beside a bank switch lands in the old bank
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_q <= '0;
            addr_q <= '0;
            fb_q <= '0;
        end else begin
            data_q <= data_d;
            addr_q <= addr_d;
            fb_q <= fb_d;
        end
    end

    // Shared registers
    // Zero start values are a choice; software must not lean on them
    always_ff @(posedge mclk) begin
        if (rst) begin
            vector_table_base_q <= `CRF_RST_LONG;
            pc_q <= `CRF_RST_LONG;
            usp_q <= `CRF_RST_WORD;
            isp_q <= `CRF_RST_WORD;
            sb_q <= `CRF_RST_WORD;
            flg_q <= `CRF_RST_FLG;
        end else begin
            vector_table_base_q <= vector_table_base_d;
            pc_q <= pc_d;
            usp_q <= usp_d;
            isp_q <= isp_d;
            sb_q <= sb_d;
            flg_q <= flg_d;
        end
    end

    // APB answer: data latched at setup, ready one cycle on;
    // fixed one-cycle access keeps the slave free of waits
    always_ff @(posedge mclk) begin
        if (rst) begin
            apb_rsp <= '0;
        end else begin
            // Ready exactly one cycle after every setup
            apb_rsp.pready <= setup;
            // Refusal rides along with ready
            apb_rsp.pslverr <= setup & ~mapped;
            // Read data taken once, stands until the next setup
            if (setup) begin
                apb_rsp.prdata <= apb_req.pwrite ? 32'h00000000 : rdata;
            end
        end
    end

    // Operand view mirrors next state, so it equals the registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            view <= '0;
        end else begin
            // Banked views follow the bank in force next cycle
            view.pair_lo <= {data_d[bank_n][2],
                data_d[bank_n][0]}; // RULE_03
            view.pair_hi <= {data_d[bank_n][3],
                data_d[bank_n][1]}; // RULE_03
            view.addr_pair <= {addr_d[bank_n][1],
                addr_d[bank_n][0]}; // RULE_05
            view.fb <= fb_d[bank_n]; // RULE_06
            // Shared registers and the flag word
            view.sb <= sb_d;
            view.vector_table_base <= vector_table_base_d; // RULE_07
            view.pc <= pc_d;
            view.asp <= asp_n; // RULE_10
            view.cpu_state_flags <= flg_d;
        end
    end

endmodule
`default_nettype wire

// *** dv/crf_regfile_asserts.sv ***
// Port checker for the banked CPU register set, bound to the design
`include "crf_params.svh"
`default_nettype none
module crf_regfile_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire crf_pkg::crf_apb_req_type apb_req,
    input wire crf_pkg::crf_apb_rsp_type apb_rsp,
    input wire crf_pkg::crf_core_type core,
    input wire crf_pkg::crf_view_type view
);
    timeunit 1ns;
    timeprecision 1ps;
    import crf_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Completed APB write
    wire logic apb_wr = apb_req.psel & apb_req.penable & apb_rsp.pready
        & apb_req.pwrite;
    // Any writer of the flag word this cycle
    wire logic flg_wr = (apb_wr & (apb_req.paddr == `CRF_OFS_FLG))
        | (core.dst_en & (core.dst_ofs == `CRF_OFS_FLG));
    // APB write with no competing core write, so APB data must land
    wire logic solo = apb_wr & ~core.dst_en;
    a_carry_take: assert property (core.flag_en |=>
        view.cpu_state_flags[`CRF_FLG_C] == $past(core.carry))
        else $error("carry flag not taken");
    a_zero_flag: assert property (
        core.flag_en && core.size == CRF_SZ16 |=>
        view.cpu_state_flags[`CRF_FLG_Z] == ($past(core.result[15:0]) == 16'h0000))
        else $error("zero flag wrong");
    a_sign_flag: assert property (
        core.flag_en && core.size == CRF_SZ8 |=>
        view.cpu_state_flags[`CRF_FLG_S] == $past(core.result[7]))
        else $error("sign flag wrong");
    a_ovf_take: assert property (core.flag_en |=>
        view.cpu_state_flags[`CRF_FLG_O] == $past(core.ovf))
        else $error("overflow flag not taken");
    a_flag_hold: assert property (
        !core.flag_en && !flg_wr |=> $stable(view.cpu_state_flags))
        else $error("flag word moved without a writer");
    a_pc_step: assert property (core.pc_en |=>
        view.pc == $past(view.pc) + $past(core.pc_step))
        else $error("pc did not advance by step");
    a_sp_write: assert property (
        solo && apb_req.paddr == `CRF_OFS_ASP |=>
        view.asp == $past(apb_req.pwdata[15:0]))
        else $error("active stack pointer not written");
    a_vector_table_base_write: assert property (
        solo && apb_req.paddr == `CRF_OFS_VECTOR_TABLE_BASE |=>
        view.vector_table_base == $past(apb_req.pwdata[19:0]))
        else $error("vector base not written");
    a_fb_write: assert property (
        solo && apb_req.paddr == `CRF_OFS_FB |=>
        view.fb == $past(apb_req.pwdata[15:0]))
        else $error("frame base not written");
    // Main scenarios reached
    c_flags: cover property (core.flag_en);
    c_step: cover property (core.pc_en);
    c_refuse: cover property (apb_rsp.pslverr);
endmodule
bind crf_regfile crf_regfile_asserts u_chk (.mclk(mclk), .rst(rst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .core(core), .view(view));
`default_nettype wire

// *** dv/crf_core_model.sv ***
// Behavioural sequencer and ALU driving the core update port
`default_nettype none
module crf_core_model (
    input wire logic mclk,
    output var crf_pkg::crf_core_type core
);
    timeunit 1ns;
    timeprecision 1ps;
    import crf_pkg::*;
    // Idle until a task asks for an update
    initial core = '0;
    // One ALU result; the debug flag is never driven to one
    task automatic alu(input crf_size_type sz, input logic [31:0] res,
        input logic c, input logic o);
        @(posedge mclk);
        core.flag_en <= 1'b1;
        core.size <= sz;
        core.result <= res;
        core.carry <= c;
        core.ovf <= o;
        @(posedge mclk);
        core.flag_en <= 1'b0;
        // The stale result is inverted so nothing leans on it
        core.result <= ~res;
    endtask
    // Register write from the sequencer
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        core.dst_en <= 1'b1;
        core.dst_ofs <= a;
        core.dst_data <= d;
        @(posedge mclk);
        core.dst_en <= 1'b0;
        core.dst_data <= ~d;
    endtask
    // Program counter advance
    task automatic step(input logic [2:0] n);
        @(posedge mclk);
        core.pc_en <= 1'b1;
        core.pc_step <= n;
        @(posedge mclk);
        core.pc_en <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** dv/crf_regfile_tb.sv ***
// Self-checking bench for the banked CPU register set
`default_nettype none
module crf_regfile_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import crf_pkg::*;
    logic mclk = 1'b0; // 125 MHz
    logic rst = 1'b1; // Synchronous reset
    crf_apb_req_type req = '0; // APB master side
    crf_apb_rsp_type rsp;
    crf_core_type core;
    crf_view_type view;
    logic [31:0] r; // Last read data
    logic e; // Last error response
    int failures = 0;
    int checks_done = 0;
    // Offset, write data, expected read; narrow registers drop top bits
    logic [71:0] rows [12] = '{
        {8'h00, 32'h1234, 32'h1234}, {8'h04, 32'h5678, 32'h5678},
        {8'h08, 32'h9ABC, 32'h9ABC}, {8'h0C, 32'hFFFFDEF0, 32'hDEF0},
        {8'h28, 32'hA5A5, 32'hA5A5}, {8'h2C, 32'h5A5A, 32'h5A5A},
        {8'h34, 32'h0F0F, 32'h0F0F}, {8'h38, 32'hFFFABCDE, 32'hABCDE},
        {8'h3C, 32'h12345, 32'h12345}, {8'h40, 32'h0111, 32'h0111},
        {8'h44, 32'h0222, 32'h0222}, {8'h48, 32'h0333, 32'h0333}};
    // Size, result, carry, overflow, expected zero and sign
    logic [37:0] ft [4] = '{
        {CRF_SZ16, 32'h0, 4'hA}, {CRF_SZ8, 32'h180, 4'h5},
        {CRF_SZ32, 32'h80000000, 4'hD}, {CRF_SZ16, 32'h10000, 4'h2}};
    crf_regfile dut (.mclk(mclk), .rst(rst), .apb_req(req),
        .apb_rsp(rsp), .core(core), .view(view));
    crf_core_model m (.mclk(mclk), .core(core));
    // Free-running clock
    initial forever #4 mclk = ~mclk;
    // Compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            failures++;
            $display("Error at %0t: got %h want %h", $time, g, x);
        end
    endtask
    // One APB transfer; pready, data and error taken at one rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) failures++;
        r = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    // Single exit point of the run
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog far beyond the few hundred cycles needed
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    // Main sequence
    initial begin
        logic [37:0] f;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        // Write all, then read all, so no register aliases another
        foreach (rows[i]) wr(rows[i][71:64], rows[i][63:32]);
        foreach (rows[i]) begin
            rd(rows[i][71:64], rows[i][31:0]);
        end
        chk(view.vector_table_base, 32'hABCDE);
        chk(view.sb, 32'h0333);
        // Every operand size, masked zero as the awkward case
        foreach (ft[i]) begin
            f = ft[i];
            m.alu(crf_size_type'(f[37:36]), f[35:4], f[3], f[2]);
            @(negedge mclk);
            chk(view.cpu_state_flags[0], f[3]);
            chk(view.cpu_state_flags[2], f[1]);
            chk(view.cpu_state_flags[3], f[0]);
            chk(view.cpu_state_flags[5], f[2]);
        end
        // Byte halves keep the other half
        wr(8'h14, 32'hAB);
        rd(8'h00, 32'hAB34);
        wr(8'h10, 32'hCD);
        rd(8'h00, 32'hABCD);
        rd(8'h10, 32'hCD);
        rd(8'h14, 32'hAB);
        wr(8'h1C, 32'h12);
        rd(8'h04, 32'h1278);
        rd(8'h18, 32'h78);
        // Register pairs
        wr(8'h20, 32'h11112222);
        rd(8'h08, 32'h1111);
        rd(8'h00, 32'h2222);
        chk(view.pair_lo, 32'h11112222);
        chk(view.pair_hi, 32'hDEF01278);
        rd(8'h24, 32'hDEF01278);
        rd(8'h20, 32'h11112222);
        wr(8'h30, 32'hAAAA5555);
        rd(8'h2C, 32'hAAAA);
        rd(8'h30, 32'hAAAA5555);
        chk(view.addr_pair, 32'hAAAA5555);
        // Second bank is an independent copy
        wr(8'h4C, 32'h10);
        rd(8'h00, 32'h0);
        wr(8'h00, 32'h00B1);
        wr(8'h34, 32'h0FB1);
        rd(8'h34, 32'h0FB1);
        chk(view.fb, 32'h0FB1);
        wr(8'h4C, 32'h0);
        rd(8'h00, 32'h2222);
        rd(8'h34, 32'h0F0F);
        // Active stack pointer follows the stack-select flag
        wr(8'h4C, 32'h80);
        wr(8'h50, 32'h0AAA);
        rd(8'h40, 32'h0AAA);
        rd(8'h44, 32'h0222);
        wr(8'h4C, 32'h0);
        wr(8'h50, 32'h0BBB);
        rd(8'h44, 32'h0BBB);
        chk(view.asp, 32'h0BBB);
        rd(8'h50, 32'h0BBB);
        // Eleven flag bits, debug flag kept clear
        wr(8'h4C, 32'hFFFFFFFD);
        rd(8'h4C, 32'h7FD);
        wr(8'h4C, 32'h0);
        // Program counter wraps at 20 bits
        wr(8'h3C, 32'hFFFFE);
        m.step(3'h3);
        @(negedge mclk);
        chk(view.pc, 32'h1);
        // Core write path
        m.put(8'h48, 32'h5A5A);
        @(negedge mclk);
        chk(view.sb, 32'h5A5A);
        // Unmapped and unaligned places are refused
        apb(1'b0, 8'h54, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        apb(1'b1, 8'h02, 32'h1);
        chk(e, 1'b1);
        rd(8'h00, 32'h2222);
        // Mid-run reset clears registers, view and answer
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk(view.pc, 32'h0);
        chk(view.sb, 32'h0);
        chk({rsp.pready, rsp.pslverr}, 32'h0);
        rd(8'h00, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
